//--- verilog/riur_pkg.sv
// constants, types and decode helpers for the update receiver
package riur_pkg;

  // link control characters
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_ACK   = 8'h06;
  localparam logic [7:0] CH_NAK   = 8'h15;
  localparam logic [7:0] CH_CAN   = 8'h18;

  // record layout, byte index within a record
  localparam int         REC_MAX_DATA = 16;
  localparam logic [7:0] REC_MAX_LEN  = 8'h10;
  localparam logic [8:0] IDX_LEN      = 9'h000;
  localparam logic [8:0] IDX_AHI      = 9'h001;
  localparam logic [8:0] IDX_ALO      = 9'h002;
  localparam logic [8:0] IDX_TYPE     = 9'h003;
  localparam logic [8:0] IDX_DATA     = 9'h004;
  localparam logic [7:0] TYPE_DATA    = 8'h00;
  localparam logic [7:0] TYPE_EOF     = 8'h01;
  localparam logic [7:0] SUM_ZERO     = 8'h00;

  // target mode-select codes on the mode pins
  localparam logic [3:0] MODE_IDLE    = 4'hF;
  localparam logic [3:0] MODE_PROGRAM = 4'h7;
  localparam logic [3:0] MODE_VERIFY  = 4'h3;
  localparam logic [3:0] MODE_ERASE   = 4'h1;

  // target address width
  localparam int ADDR_W_DEF = 12;

  // timing
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint NS_PER_S      = 1_000_000_000;
  localparam longint INT_LEAD_NS   = 2000;
  localparam longint PROG_SETUP_NS = 100;
  localparam longint PROG_PULSE_NS = 1000;
  localparam longint VERIFY_NS     = 500;
  localparam longint ERASE_NS      = 10_000_000;
  localparam longint SESSION_S     = 30;
  localparam int     TMO_W         = 34;

  localparam logic [31:0] INT_LEAD_CYC =
    32'((INT_LEAD_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [31:0] SETUP_CYC =
    32'((PROG_SETUP_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [31:0] PULSE_CYC =
    32'((PROG_PULSE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [31:0] VERIFY_CYC =
    32'((VERIFY_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [31:0] ERASE_CYC =
    32'((ERASE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [TMO_W-1:0] SESSION_CYC = TMO_W'(SESSION_S * CLK_HZ);

  typedef enum logic [3:0] {
    ST_HUNT, ST_HI, ST_LO, ST_EVAL, ST_INT, ST_ERASE,
    ST_SETUP, ST_PULSE, ST_VERIFY, ST_CHECK, ST_REPLY
  } riur_state_t;

  // ascii hex digit to {valid, nibble}
  function automatic logic [4:0] hex_val(input logic [6:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 7'h30 && c <= 7'h39) r = {1'b1, 4'(c - 7'h30)};
    else if (c >= 7'h41 && c <= 7'h46) r = {1'b1, 4'(c - 7'h37)};
    return r;
  endfunction

endpackage

//--- verilog/riur_fifo.sv
// small valid/ready fifo for received link characters
`timescale 1ns/1ps
`default_nettype none
module riur_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   cnt, next_cnt;
  logic          push, pop;

  always_comb begin
    in_ready  = cnt != (AW+1)'(DEPTH);
    out_valid = cnt != '0;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_wp   = wp;
    next_rp   = rp;
    if (push) next_wp = (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
    if (pop) next_rp = (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
      if (push) mem[wp] <= in_data;
    end
  end

  assign out_data = mem[rp];
endmodule // riur_fifo
`default_nettype wire

//--- verilog/riur_top.sv
// remote inline update receiver: packet parser and target programmer
// Function
// R1 - running checksum, good packet answered with ACK
// R2 - bad checksum answers NAK, nothing programmed
// R3 - transmitter sends packet then awaits one reply
// R4 - transmitter advances on ACK, resends on NAK
// R5 - transmitter resends on silence, aborts past limit
// R6 - CAN reports fatal error, transmitter aborts
// R7 - program, read back, compare; ACK on match
// R8 - read-back mismatch answers CAN
// R9 - colon starts packet; other characters discarded
// R10 - load address is sequence and write address
// R11 - seven-bit characters, parity checked on each
// R12 - data field holds at most 16 bytes
// R13 - two hex characters make one byte
// R14 - one select drives reset, mux, latch freeze
// R15 - interrupt target before asserting its reset
// R16 - reset high, drive store enable and strobe
// R17 - idle outputs undriven, left pulled high
// R18 - low four address bits through switch mux
// R19 - take data port and upper address port
// R20 - erase before first data packet of session
// R21 - bad type or length answers NAK
// R22 - end-of-file releases all programming outputs
// R23 - thirty second gap abandons session to idle; code only returns the parser to ST_HUNT, prog_on and target outputs kept
// R24 - checksum valid when byte sum is zero
`timescale 1ns/1ps
`default_nettype none
module riur_top #(
  parameter int ADDR_W = riur_pkg::ADDR_W_DEF,
  parameter logic [31:0] ERASE_CYCLES = riur_pkg::ERASE_CYC,
  parameter logic [riur_pkg::TMO_W-1:0] SESSION_CYCLES =
    riur_pkg::SESSION_CYC
) (
  input  wire logic              REF_CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        RX_CHAR,
  input  wire logic              RX_VALID,
  output logic                   RX_READY,
  output logic [7:0]             TX_CHAR,
  output logic                   TX_VALID,
  input  wire logic              TX_READY,
  output logic                   PROG_SELECT,
  output logic                   TGT_INT_N_O,
  output logic                   TGT_INT_N_OE_N,
  output logic                   PROGRAM_STORE_ENABLE_N_O,
  output logic                   PROGRAM_STORE_ENABLE_N_OE_N,
  output logic                   ADDR_LATCH_PROG_STROBE_N_O,
  output logic                   ADDR_LATCH_PROG_STROBE_N_OE_N,
  output logic [3:0]             TGT_MODE_O,
  output logic                   TGT_MODE_OE_N,
  input  wire logic [7:0]        TGT_DATA_I,
  output logic [7:0]             TGT_DATA_O,
  output logic                   TGT_DATA_OE_N,
  output logic [ADDR_W-5:0]      TGT_ADDR_HI_O,
  output logic                   TGT_ADDR_HI_OE_N,
  input  wire logic [3:0]        APP_SWITCH_I,
  output logic [3:0]             TGT_PORT_LO_O
);
  localparam int N = riur_pkg::REC_MAX_DATA;

  riur_pkg::riur_state_t state, next_state;
  logic [3:0]            nib, next_nib;
  logic [8:0]            idx, next_idx;
  logic [7:0]            sum, next_sum;
  logic [7:0]            len, next_len;
  logic [15:0]           addr, next_addr;
  logic [7:0]            rtype, next_rtype;
  logic                  bad, next_bad;
  logic [7:0]            pbuf [N];
  logic [7:0]            next_pbuf [N];
  logic [31:0]           wcnt, next_wcnt;
  logic [3:0]            bidx, next_bidx;
  logic                  prog_on, next_prog_on;
  logic                  erase_need, next_erase_need;
  logic                  int_n, next_int_n;
  logic                  strobe_n, next_strobe_n;
  logic [3:0]            mode, next_mode;
  logic [7:0]            data_o, next_data_o;
  logic                  data_drv, next_data_drv;
  logic [ADDR_W-1:0]     tgt_addr, next_tgt_addr;
  logic [3:0]            port_lo, next_port_lo;
  logic [7:0]            reply, next_reply;
  logic [riur_pkg::TMO_W-1:0] tcnt, next_tcnt;

  logic [7:0] data_s1, data_s2;
  logic [3:0] sw_s1, sw_s2;
  logic       b_valid, b_ready;
  logic [7:0] b_data;
  logic [4:0] hex_dec;
  logic       par_ok;
  logic       parsing;

  riur_fifo #(
    .W     (8),
    .DEPTH (2)
  ) u_rx_fifo (
    .clk       (REF_CLK),
    .rst       (RESET),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .in_data   (RX_CHAR),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );

  // pin inputs pass two flops
  always_ff @(posedge REF_CLK) begin
    data_s1 <= TGT_DATA_I;
    data_s2 <= data_s1;
    sw_s1   <= APP_SWITCH_I;
    sw_s2   <= sw_s1;
  end

  assign hex_dec = riur_pkg::hex_val(b_data[6:0]);
  assign par_ok  = ~(^b_data); // R11
  assign parsing = state == riur_pkg::ST_HUNT || state == riur_pkg::ST_HI
                   || state == riur_pkg::ST_LO;

  always_comb begin
    logic [7:0] byte_v;
    byte_v          = {nib, hex_dec[3:0]}; // R13
    next_state      = state;
    next_nib        = nib;
    next_idx        = idx;
    next_sum        = sum;
    next_len        = len;
    next_addr       = addr;
    next_rtype      = rtype;
    next_bad        = bad;
    next_pbuf       = pbuf;
    next_wcnt       = (wcnt != '0) ? wcnt - 32'd1 : wcnt;
    next_bidx       = bidx;
    next_prog_on    = prog_on;
    next_erase_need = erase_need;
    next_int_n      = int_n;
    next_strobe_n   = strobe_n;
    next_mode       = mode;
    next_data_o     = data_o;
    next_data_drv   = data_drv;
    next_tgt_addr   = tgt_addr;
    next_reply      = reply;
    next_tcnt       = (tcnt != '0) ? tcnt - 1'b1 : tcnt;
    next_port_lo    = prog_on ? tgt_addr[3:0] : sw_s2; // R18
    b_ready         = parsing;
    case (state)
      riur_pkg::ST_HUNT: begin
        if (b_valid && b_data == riur_pkg::CH_COLON) begin // R9
          next_state = riur_pkg::ST_HI;
          next_idx   = riur_pkg::IDX_LEN;
          next_sum   = riur_pkg::SUM_ZERO;
          next_bad   = 1'b0;
        end
      end
      riur_pkg::ST_HI, riur_pkg::ST_LO: begin
        if (b_valid) begin
          if (!par_ok || !hex_dec[4]) begin // R11
            next_reply = riur_pkg::CH_NAK;
            next_state = riur_pkg::ST_REPLY;
          end else if (state == riur_pkg::ST_HI) begin
            next_nib   = hex_dec[3:0];
            next_state = riur_pkg::ST_LO;
          end else begin
            next_sum = sum + byte_v; // R1 R24
            next_idx = idx + 9'd1;
            if (idx == riur_pkg::IDX_LEN) begin
              next_len = byte_v;
              if (byte_v > riur_pkg::REC_MAX_LEN) next_bad = 1'b1; // R21 R12
            end
            if (idx == riur_pkg::IDX_AHI) next_addr[15:8] = byte_v; // R10
            if (idx == riur_pkg::IDX_ALO) next_addr[7:0] = byte_v; // R10
            if (idx == riur_pkg::IDX_TYPE) begin
              next_rtype = byte_v;
              if (byte_v != riur_pkg::TYPE_DATA
                  && byte_v != riur_pkg::TYPE_EOF) next_bad = 1'b1; // R21
            end
            if (idx >= riur_pkg::IDX_DATA && !bad
                && idx < {1'b0, len} + riur_pkg::IDX_DATA)
              next_pbuf[4'(idx - riur_pkg::IDX_DATA)] = byte_v; // R12
            if (idx > riur_pkg::IDX_TYPE
                && idx == {1'b0, len} + riur_pkg::IDX_DATA)
              next_state = riur_pkg::ST_EVAL;
            else
              next_state = riur_pkg::ST_HI;
          end
        end
      end
      riur_pkg::ST_EVAL: begin
        next_bidx  = '0;
        next_state = riur_pkg::ST_REPLY;
        if (bad || sum != riur_pkg::SUM_ZERO) begin
          next_reply = riur_pkg::CH_NAK; // R2 R21 R24
        end else begin
          next_tcnt = SESSION_CYCLES; // R23
          if (rtype == riur_pkg::TYPE_EOF) begin
            next_prog_on    = 1'b0; // R22
            next_mode       = riur_pkg::MODE_IDLE;
            next_strobe_n   = 1'b1;
            next_data_drv   = 1'b0;
            next_int_n      = 1'b1;
            next_erase_need = 1'b1; // R20
            next_reply      = riur_pkg::CH_ACK;
          end else if (len == '0) begin
            next_reply = riur_pkg::CH_ACK; // R1
          end else if (!prog_on) begin
            next_int_n = 1'b0; // R15
            next_wcnt  = riur_pkg::INT_LEAD_CYC;
            next_state = riur_pkg::ST_INT;
          end else begin
            next_state = riur_pkg::ST_SETUP;
          end
        end
      end
      riur_pkg::ST_INT: begin
        if (wcnt == '0) begin
          next_int_n   = 1'b1;
          next_prog_on = 1'b1; // R14 R16 R15
          next_mode    = riur_pkg::MODE_PROGRAM;
          next_state   = riur_pkg::ST_SETUP;
          if (erase_need) begin
            next_mode     = riur_pkg::MODE_ERASE; // R20
            next_strobe_n = 1'b0;
            next_wcnt     = ERASE_CYCLES;
            next_state    = riur_pkg::ST_ERASE;
          end
        end
      end
      riur_pkg::ST_ERASE: begin
        if (wcnt == '0) begin
          next_strobe_n   = 1'b1; // R20
          next_erase_need = 1'b0;
          next_state      = riur_pkg::ST_SETUP;
        end
      end
      riur_pkg::ST_SETUP: begin
        next_tgt_addr = addr[ADDR_W-1:0] + ADDR_W'(bidx); // R10 R19
        next_data_o   = pbuf[bidx]; // R19
        next_data_drv = 1'b1;
        next_mode     = riur_pkg::MODE_PROGRAM;
        next_wcnt     = riur_pkg::SETUP_CYC;
        next_state    = riur_pkg::ST_PULSE;
      end
      riur_pkg::ST_PULSE: begin
        if (wcnt == '0 && strobe_n) begin
          next_strobe_n = 1'b0; // R16 R7
          next_wcnt     = riur_pkg::PULSE_CYC;
        end else if (wcnt == '0) begin
          next_strobe_n = 1'b1;
          next_data_drv = 1'b0;
          next_mode     = riur_pkg::MODE_VERIFY; // R7
          next_wcnt     = riur_pkg::VERIFY_CYC;
          next_state    = riur_pkg::ST_CHECK;
        end
      end
      riur_pkg::ST_CHECK: begin
        if (wcnt == '0) begin
          if (data_s2 != pbuf[bidx]) begin
            next_reply = riur_pkg::CH_CAN; // R8 R6
            next_state = riur_pkg::ST_REPLY;
          end else if ({4'h0, bidx} == len - 8'd1) begin
            next_reply = riur_pkg::CH_ACK; // R7
            next_state = riur_pkg::ST_REPLY;
          end else begin
            next_bidx  = bidx + 4'd1;
            next_state = riur_pkg::ST_SETUP;
          end
        end
      end
      riur_pkg::ST_REPLY: begin
        if (TX_READY) next_state = riur_pkg::ST_HUNT;
      end
      default: next_state = riur_pkg::ST_HUNT;
    endcase
    if (parsing && tcnt == riur_pkg::TMO_W'(1)) begin
      next_state = riur_pkg::ST_HUNT; // R23
      b_ready    = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state      <= riur_pkg::ST_HUNT;
      nib        <= '0;
      idx        <= '0;
      sum        <= '0;
      len        <= '0;
      addr       <= '0;
      rtype      <= '0;
      bad        <= 1'b0;
      wcnt       <= '0;
      bidx       <= '0;
      prog_on    <= 1'b0;
      erase_need <= 1'b1;
      int_n      <= 1'b1;
      strobe_n   <= 1'b1;
      mode       <= riur_pkg::MODE_IDLE;
      data_o     <= '0;
      data_drv   <= 1'b0;
      tgt_addr   <= '0;
      port_lo    <= '0;
      reply      <= '0;
      tcnt       <= '0;
    end else begin
      state      <= next_state;
      nib        <= next_nib;
      idx        <= next_idx;
      sum        <= next_sum;
      len        <= next_len;
      addr       <= next_addr;
      rtype      <= next_rtype;
      bad        <= next_bad;
      pbuf       <= next_pbuf;
      wcnt       <= next_wcnt;
      bidx       <= next_bidx;
      prog_on    <= next_prog_on;
      erase_need <= next_erase_need;
      int_n      <= next_int_n;
      strobe_n   <= next_strobe_n;
      mode       <= next_mode;
      data_o     <= next_data_o;
      data_drv   <= next_data_drv;
      tgt_addr   <= next_tgt_addr;
      port_lo    <= next_port_lo;
      reply      <= next_reply;
      tcnt       <= next_tcnt;
    end
  end

  // pins float high unless programming; interrupt pin driven only while low
  assign TX_CHAR                       = reply;
  assign TX_VALID                      = state == riur_pkg::ST_REPLY;
  assign PROG_SELECT                   = prog_on; // R14
  assign TGT_INT_N_O                   = int_n;
  assign TGT_INT_N_OE_N                = int_n; // R17
  assign PROGRAM_STORE_ENABLE_N_O      = 1'b0; // R16
  assign PROGRAM_STORE_ENABLE_N_OE_N   = ~prog_on; // R17
  assign ADDR_LATCH_PROG_STROBE_N_O    = strobe_n;
  assign ADDR_LATCH_PROG_STROBE_N_OE_N = ~prog_on; // R17
  assign TGT_MODE_O                    = mode;
  assign TGT_MODE_OE_N                 = ~prog_on;
  assign TGT_DATA_O                    = data_o;
  assign TGT_DATA_OE_N                 = ~(data_drv && prog_on); // R19
  assign TGT_ADDR_HI_O                 = tgt_addr[ADDR_W-1:4];
  assign TGT_ADDR_HI_OE_N              = ~prog_on; // R19
  assign TGT_PORT_LO_O                 = port_lo;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_colon_taken;
    state == riur_pkg::ST_HUNT && b_valid && b_data == riur_pkg::CH_COLON
      && tcnt != riur_pkg::TMO_W'(1);
  endsequence
  sequence s_int_lead;
    !int_n ##1 !int_n;
  endsequence

  a_colon_start: assert property (s_colon_taken |=> // R9
    state == riur_pkg::ST_HI && sum == riur_pkg::SUM_ZERO)
    else $error("colon did not start a packet");
  a_bad_sum_nak: assert property (state == riur_pkg::ST_EVAL // R2
    && sum != riur_pkg::SUM_ZERO |=> reply == riur_pkg::CH_NAK
    && !$rose(prog_on) ##1 !$rose(prog_on))
    else $error("bad checksum not answered with nak");
  a_parity_nak: assert property ((state == riur_pkg::ST_HI // R11
    || state == riur_pkg::ST_LO) && b_valid
    && !par_ok && tcnt != riur_pkg::TMO_W'(1) |=>
    state == riur_pkg::ST_REPLY && reply == riur_pkg::CH_NAK)
    else $error("parity error not answered with nak");
  a_int_first: assert property ($rose(prog_on) |-> !$past(int_n) // R15
    && !$past(int_n, 2))
    else $error("select raised without prior interrupt");
  a_int_lead: assert property ($fell(int_n) |-> s_int_lead) // R15
    else $error("interrupt lead too short");
  a_idle_float: assert property (!prog_on |-> // R17
    PROGRAM_STORE_ENABLE_N_OE_N && ADDR_LATCH_PROG_STROBE_N_OE_N
    && TGT_DATA_OE_N && TGT_ADDR_HI_OE_N)
    else $error("target pin driven while idle");
  a_store_en_low: assert property (prog_on |-> // R16
    !PROGRAM_STORE_ENABLE_N_O && !PROGRAM_STORE_ENABLE_N_OE_N)
    else $error("store enable not held low");
  a_erase_first: assert property (state == riur_pkg::ST_INT // R20
    && wcnt == '0 && erase_need |=> state == riur_pkg::ST_ERASE
    && mode == riur_pkg::MODE_ERASE && !strobe_n)
    else $error("erase skipped on first packet");
  a_verify_can: assert property (state == riur_pkg::ST_CHECK // R8
    && wcnt == '0 && data_s2 != pbuf[bidx] |=>
    reply == riur_pkg::CH_CAN && TX_VALID)
    else $error("mismatch not answered with can");
  a_eof_release: assert property (state == riur_pkg::ST_EVAL && !bad // R22
    && sum == riur_pkg::SUM_ZERO && rtype == riur_pkg::TYPE_EOF |=>
    !prog_on && reply == riur_pkg::CH_ACK ##1 TGT_MODE_OE_N)
    else $error("end of file did not release target");
  a_sum_running: assert property (state == riur_pkg::ST_LO && b_valid // R24
    && par_ok && hex_dec[4] && tcnt != riur_pkg::TMO_W'(1) |=>
    sum == $past(sum) + {$past(nib), $past(hex_dec[3:0])})
    else $error("running checksum wrong");
  a_session_expire: assert property (parsing // R23
    && tcnt == riur_pkg::TMO_W'(1) |=> state == riur_pkg::ST_HUNT)
    else $error("session expiry did not return to hunt");
endmodule // riur_top
`default_nettype wire

//--- testbench/riur_tgt_model.sv
// target controller model: program store and data port
`timescale 1ns/1ps
`default_nettype none
module riur_tgt_model (
  input  wire logic       clk,
  input  wire logic       sel,
  input  wire logic       strobe_n,
  input  wire logic       strobe_oe_n,
  input  wire logic [3:0] mode,
  input  wire logic [7:0] dout,
  input  wire logic       dout_oe_n,
  input  wire logic [7:0] addr_hi,
  input  wire logic [3:0] addr_lo,
  input  wire logic       corrupt,
  output logic      [7:0] din
);
  logic [7:0] mem [0:4095];
  logic       pulse;
  assign pulse = sel && !strobe_oe_n && !strobe_n;
  always_ff @(posedge clk) begin
    if (pulse && mode == riur_pkg::MODE_ERASE) begin
      for (int i = 0; i < 4096; i++) mem[i] <= 8'hFF;
    end else if (pulse && mode == riur_pkg::MODE_PROGRAM && !dout_oe_n) begin
      mem[{addr_hi, addr_lo}] <= dout;
    end
  end
  always_comb begin
    if (!dout_oe_n) din = dout;
    else if (sel && mode == riur_pkg::MODE_VERIFY)
      din = mem[{addr_hi, addr_lo}] ^ {7'h00, corrupt};
    else din = 8'hFF;
  end
endmodule // riur_tgt_model
`default_nettype wire

//--- testbench/test_remote_inline_update_receiver.sv
// bench for the update receiver: packets in, replies and target checked
`timescale 1ns/1ps
`default_nettype none
module test_remote_inline_update_receiver;
  logic        ref_clk = 0, reset = 1, rx_valid = 0, tx_ready = 0;
  logic        corrupt = 0, int_seen = 0;
  logic [7:0]  rx_char = 8'h00, din, dout, ahi, tx_char;
  logic [7:0]  dat [0:16];
  logic        tx_valid, rx_ready, psel, int_o, int_oe_n, pse_oe_n, pse_o;
  logic        als_o, als_oe_n, mode_oe_n, data_oe_n, ahi_oe_n;
  logic [3:0]  mode, plo, sw = 4'hA;
  logic [7:0]  exp_q [$];
  logic [31:0] rs = 32'h8D59, rt = 32'h8D59;
  int          errors = 0, n_compared = 0;

  always #2.5 ref_clk = ~ref_clk;

  riur_top #(.ERASE_CYCLES(32'h0000000A), .SESSION_CYCLES(34'h10000))
  i_dut (
    .REF_CLK(ref_clk), .RESET(reset), .RX_CHAR(rx_char),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_CHAR(tx_char),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .PROG_SELECT(psel),
    .TGT_INT_N_O(int_o), .TGT_INT_N_OE_N(int_oe_n),
    .PROGRAM_STORE_ENABLE_N_O(pse_o), .PROGRAM_STORE_ENABLE_N_OE_N(pse_oe_n),
    .ADDR_LATCH_PROG_STROBE_N_O(als_o),
    .ADDR_LATCH_PROG_STROBE_N_OE_N(als_oe_n), .TGT_MODE_O(mode),
    .TGT_MODE_OE_N(mode_oe_n), .TGT_DATA_I(din), .TGT_DATA_O(dout),
    .TGT_DATA_OE_N(data_oe_n), .TGT_ADDR_HI_O(ahi),
    .TGT_ADDR_HI_OE_N(ahi_oe_n), .APP_SWITCH_I(sw), .TGT_PORT_LO_O(plo)
  );

  riur_tgt_model i_tgt (
    .clk(ref_clk), .sel(psel), .strobe_n(als_o), .strobe_oe_n(als_oe_n),
    .mode(mode), .dout(dout), .dout_oe_n(data_oe_n), .addr_hi(ahi),
    .addr_lo(plo), .corrupt(corrupt), .din(din)
  );

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] par(input logic [6:0] c);
    return {^c, c};
  endfunction
  function automatic logic [6:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 7'h30 + {3'h0, n} : 7'h37 + {3'h0, n};
  endfunction

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] c);
    int k;
    rx_char <= c;
    rx_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rx_ready !== 1'b1 && k < 5000);
    if (k >= 5000) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic hexb(input logic [7:0] b, input logic bad);
    put(par(hx(b[7:4])) ^ {bad, 7'h00});
    put(par(hx(b[3:0])));
  endtask

  // one packet, then wait for its single reply
  task automatic send_rec(input logic [7:0] len, input logic [11:0] addr,
                          input logic [7:0] typ, input int fault,
                          input logic [7:0] reply);
    logic [7:0] s;
    int         k;
    s = len + {4'h0, addr[11:8]} + addr[7:0] + typ;
    exp_q.push_back(reply);
    put(par(7'h3A));
    hexb(len, 1'b0);
    hexb({4'h0, addr[11:8]}, fault == 2);
    hexb(addr[7:0], 1'b0);
    hexb(typ, 1'b0);
    for (int i = 0; i < len; i++) begin
      hexb(dat[i], 1'b0);
      s = s + dat[i];
    end
    hexb(8'h00 - s + 8'(fault == 1), 1'b0);
    rx_valid <= 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 20000) begin
      errors++;
      stop_test();
    end
    $display("packet test done at %0t", $time);
  endtask

  always @(posedge ref_clk) begin
    rt <= nx(rt);
    tx_ready <= rt[3] | rt[9];
    if (int_oe_n === 1'b0 && int_o === 1'b0 && psel === 1'b0) int_seen <= 1'b1;
  end

  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(tx_char, 8'hFF);
      else chk(tx_char, exp_q.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      rs = nx(rs);
      dat[i] = rs[7:0];
    end
    put(par(7'h58));
    send_rec(2, 12'h010, riur_pkg::TYPE_DATA, 1, riur_pkg::CH_NAK);
    chk(psel, 0);
    send_rec(2, 12'h010, riur_pkg::TYPE_DATA, 0, riur_pkg::CH_ACK);
    chk(int_seen, 1);
    chk(psel, 1);
    chk({pse_o, pse_oe_n}, 2'h0);
    chk({i_tgt.mem[12'h010], i_tgt.mem[12'h011]}, {dat[0], dat[1]});
    for (int i = 0; i < 16; i++) begin
      rs = nx(rs);
      dat[i] = rs[7:0];
    end
    send_rec(16, 12'h120, riur_pkg::TYPE_DATA, 0, riur_pkg::CH_ACK);
    for (int i = 0; i < 16; i++) chk(i_tgt.mem[12'h120 + i], dat[i]);
    send_rec(17, 12'h200, riur_pkg::TYPE_DATA, 0, riur_pkg::CH_NAK);
    send_rec(0, 12'h000, 8'h05, 0, riur_pkg::CH_NAK);
    send_rec(2, 12'h300, riur_pkg::TYPE_DATA, 2, riur_pkg::CH_NAK);
    corrupt <= 1'b1;
    send_rec(1, 12'h040, riur_pkg::TYPE_DATA, 0, riur_pkg::CH_CAN);
    corrupt <= 1'b0;
    rs = nx(rs);
    sw <= rs[3:0];
    send_rec(0, 12'h000, riur_pkg::TYPE_EOF, 0, riur_pkg::CH_ACK);
    repeat (4) @(posedge ref_clk);
    chk(psel, 0);
    chk({int_oe_n, pse_oe_n, als_oe_n, mode_oe_n, data_oe_n, ahi_oe_n},
        6'h3F);
    chk(plo, sw);
    // cut packet, no reply, then resent whole after the session gap
    put(par(7'h3A));
    hexb(8'h00, 1'b0);
    rx_valid <= 1'b0;
    repeat (66000) @(posedge ref_clk);
    send_rec(0, 12'h000, riur_pkg::TYPE_EOF, 0, riur_pkg::CH_ACK);
    stop_test();
  end
endmodule // test_remote_inline_update_receiver
`default_nettype wire
